// ---- hdl/csa_pkg.sv ----
/*
 * Package of the clock status and auxiliary clock select block: register
 * byte addresses, field positions, reset values, source codes and counts.
 * Assumes a 32-bit APB slave on ref_clk; one register per word.
 */
package csa_pkg;
    // Register byte addresses
    localparam logic [31:0] CSA_ADDR_CONFIG = 32'h4030_0000;
    localparam logic [31:0] CSA_ADDR_STATUS = 32'h4030_0004;
    localparam logic [31:0] CSA_ADDR_CONV = 32'h4030_0008;
    localparam logic [31:0] CSA_ADDR_PIN = 32'h4030_000C;
    localparam logic [31:0] CSA_ADDR_FORCE = 32'h4030_0010;
    // Field positions
    localparam int CSA_CFG_REQ_LSB = 0;
    localparam int CSA_CFG_MON_LSB = 6;
    localparam int CSA_CFG_LOSS_IE_BIT = 20;
    localparam int CSA_STS_LOSS_BIT = 3;
    localparam int CSA_STS_SRC_LSB = 0;
    localparam int CSA_CONV_SEL_LSB = 4;
    localparam int CSA_CONV_DIV_LSB = 0;
    localparam int CSA_PIN_SEL_LSB = 8;
    localparam int CSA_PIN_DIV_LSB = 0;
    localparam int CSA_DMA_FORCE_BIT = 10;
    // Reset values
    localparam logic [2:0] CSA_RST_REQ = 3'h0;
    localparam logic [1:0] CSA_RST_MON = 2'h0;
    localparam logic CSA_RST_LOSS_IE = 1'b1;
    localparam logic [2:0] CSA_RST_SEL = 3'h7;
    localparam logic [2:0] CSA_RST_CONV_DIV = 3'h0;
    localparam logic [7:0] CSA_RST_PIN_DIV = 8'h00;
    localparam logic [31:0] CSA_RST_FORCE = 32'h0000_0000;
    // Source codes shared by status, converter and pin selects
    typedef enum logic [2:0] {
        CSA_SRC_FAST_RC = 3'b000,
        CSA_SRC_SLOW_RC = 3'b001,
        CSA_SRC_FAST_XTAL = 3'b010,
        CSA_SRC_SLOW_XTAL = 3'b011,
        CSA_SRC_PIN = 3'b100,
        CSA_SRC_PRESYS = 3'b101,
        CSA_SRC_RSVD = 3'b110,
        CSA_SRC_OFF = 3'b111
    } csa_src_e;
    // Number of sampled clock sources
    localparam int CSA_NSRC = 6;
    // Rising edges of the new source needed before a switch completes
    localparam logic [1:0] CSA_SWITCH_EDGES = 2'h2;
    // Monitor windows in slow RC periods, minus one
    localparam logic [6:0] CSA_MON_WIN1 = 7'h03;
    localparam logic [6:0] CSA_MON_WIN2 = 7'h0F;
    localparam logic [6:0] CSA_MON_WIN3 = 7'h3F;
endpackage

// ---- hdl/csa_clock_ctrl.sv ----
/*
 * Clock status and auxiliary clock select: APB registers, active system
 * clock tracking with loss monitor, converter and output pin clock
 * generators, peripheral bus clock enables.
 * Assumes all oscillators arrive as plain levels sampled by ref_clk, which
 * must run well above twice the fastest of them.
 */
//Operation
//- Status register ignores all writes
//- Loss flag set on fallback to slow RC
//- Status source codes zero to four
//- Status changes only after switch completes, on loss fallback or when a config write clears the loss flag
//- Converter select codes, seven disables
//- Converter divides by two to the field
//- Converter bit three reads zero
//- Pin select codes, seven disables output
//- Pin clock is source over divide plus one
//- Force bit holds bus clock on
//- Otherwise bus clock follows peripheral activity
//- DMA write sets DMA force bit
//- System source requested in config field
//- Monitor window off, 4, 16, 64
//- Loss interrupt gated by enable bit
`timescale 1ns/10ps
module csa_clock_ctrl #(
    parameter int NPERIPH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    input wire logic fast_crystal_osc,
    input wire logic slow_crystal_osc,
    input wire logic pin_clock_source,
    input wire logic predivided_system_clock,
    input wire logic dma_write,
    input wire logic [31:0] periph_active,
    output logic [31:0] periph_clk_en,
    output logic converter_clock,
    output logic output_pin_clock,
    output logic clk_loss_irq
);
    import csa_pkg::*;

    // Force register and enables are one word wide
    if (NPERIPH != 32) begin : g_chk
        $error("NPERIPH must be 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [CSA_NSRC-1:0] sync1;    // Synchroniser first stage
        logic [CSA_NSRC-1:0] sync2;
        logic [CSA_NSRC-1:0] sync3;
        logic [CSA_NSRC-1:0] filt;     // Accepted source levels
        logic [2:0] sys_req;           // Requested system source
        logic [1:0] mon_per;           // Monitor window code
        logic loss_ie;                 // Loss interrupt enable
        logic [2:0] active_src;        // Source in use
        logic loss;                    // Loss flag
        logic [1:0] sw_cnt;            // Edges seen of requested source
        logic [6:0] mon_cnt;           // Slow RC periods in window
        logic act_seen;                // Active source rose in window
        logic [2:0] cv_sel;            // Converter select as written
        logic [2:0] cv_div;
        logic [2:0] cv_act_sel;        // Converter select in effect
        logic [2:0] cv_act_div;
        logic [6:0] cv_cnt;
        logic cv_out;
        logic [2:0] op_sel;            // Pin select as written
        logic [7:0] op_div;
        logic [2:0] op_act_sel;        // Pin select in effect
        logic [7:0] op_act_div;
        logic [7:0] op_cnt;
        logic op_out;
        logic [31:0] force_en;         // Force register
        logic [31:0] clk_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } csa_state_s;

    csa_state_s st;
    csa_state_s next_st;

    // Both edges and rising edges of each accepted source
    logic [CSA_NSRC-1:0] next_filt;
    logic [CSA_NSRC-1:0] src_edge;
    logic [CSA_NSRC-1:0] src_rise;
    logic setup;                       // APB setup cycle
    logic access;                      // APB access cycle, write/read point
    logic cv_edge;
    logic op_edge;
    logic [6:0] cv_thr;
    logic [6:0] mon_win;

    // Edge of the selected source; reserved and off codes give none
    function automatic logic sel_edge(input logic [2:0] sel,
                                      input logic [CSA_NSRC-1:0] e);
        sel_edge = (sel <= CSA_SRC_PRESYS) ? e[sel] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        setup = psel && !penable;
        access = psel && penable && st.pready;
        // A rise counts once the second and third stages agree; any disagreement forces the level low
        next_st.sync1 = {predivided_system_clock, pin_clock_source, slow_crystal_osc,
                         fast_crystal_osc, slow_rc_osc, fast_rc_osc};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_filt = (st.filt & ~(st.sync2 ^ st.sync3)) | (st.sync3 & (st.sync2 ~^ st.sync3));
        next_st.filt = next_filt;
        src_edge = st.filt ^ next_filt;
        src_rise = ~st.filt & next_filt;

        // Register writes at the access edge
        if (access && pwrite) begin
            case (paddr)
                CSA_ADDR_CONFIG: begin
                    next_st.sys_req = pwdata[CSA_CFG_REQ_LSB +: 3];
                    next_st.mon_per = pwdata[CSA_CFG_MON_LSB +: 2];
                    next_st.loss_ie = pwdata[CSA_CFG_LOSS_IE_BIT];
                    next_st.loss = 1'b0;
                end
                CSA_ADDR_CONV: begin
                    next_st.cv_sel = pwdata[CSA_CONV_SEL_LSB +: 3];
                    next_st.cv_div = pwdata[CSA_CONV_DIV_LSB +: 3];
                end
                CSA_ADDR_PIN: begin
                    next_st.op_sel = pwdata[CSA_PIN_SEL_LSB +: 3];
                    next_st.op_div = pwdata[CSA_PIN_DIV_LSB +: 8];
                end
                CSA_ADDR_FORCE: next_st.force_en = pwdata;
                // Status writes are dropped here on purpose
                default: ;
            endcase
        end
        // The DMA set wins over a clearing write in the same cycle
        if (dma_write) begin
            next_st.force_en[CSA_DMA_FORCE_BIT] = 1'b1;
        end
        // Bus clocks on when forced or when the peripheral wants them
        next_st.clk_en = st.force_en | periph_active;

        // System switch: only once the requested source really runs
        if (st.sys_req <= CSA_SRC_PIN && st.sys_req != st.active_src) begin
            if (src_rise[st.sys_req]) begin
                next_st.sw_cnt = st.sw_cnt + 2'h1;
                if (st.sw_cnt + 2'h1 >= CSA_SWITCH_EDGES) begin
                    next_st.active_src = st.sys_req;
                    next_st.sw_cnt = 2'h0;
                end
            end
        end else begin
            // Reserved requests are ignored
            next_st.sw_cnt = 2'h0;
        end

        // Loss monitor clocked by slow RC periods
        case (st.mon_per)
            2'h1: mon_win = CSA_MON_WIN1;
            2'h2: mon_win = CSA_MON_WIN2;
            default: mon_win = CSA_MON_WIN3;
        endcase
        if (src_rise[st.active_src]) begin
            next_st.act_seen = 1'b1;
        end
        if (st.mon_per == 2'h0 || st.active_src == CSA_SRC_SLOW_RC) begin
            next_st.mon_cnt = 7'h00;
            next_st.act_seen = 1'b0;
        end else if (src_rise[CSA_SRC_SLOW_RC]) begin
            next_st.mon_cnt = st.mon_cnt + 7'h01;
            if (st.mon_cnt >= mon_win) begin
                next_st.mon_cnt = 7'h00;
                next_st.act_seen = 1'b0;
                if (!st.act_seen) begin
                    // Fall back to the slow RC and flag it
                    next_st.active_src = CSA_SRC_SLOW_RC;
                    next_st.loss = 1'b1;
                    next_st.sw_cnt = 2'h0;
                end
            end
        end
        next_st.irq = st.loss && st.loss_ie;

        // Converter clock: new setting taken only while output is low
        cv_edge = sel_edge(st.cv_act_sel, src_edge);
        cv_thr = 7'((8'h01 << st.cv_act_div) - 8'h01);
        if (!st.cv_out && {st.cv_sel, st.cv_div} != {st.cv_act_sel, st.cv_act_div}) begin
            next_st.cv_act_sel = st.cv_sel;
            next_st.cv_act_div = st.cv_div;
            next_st.cv_cnt = 7'h00;
        end else if (cv_edge) begin
            // Toggle every 2^div source half periods
            if (st.cv_cnt >= cv_thr) begin
                next_st.cv_cnt = 7'h00;
                next_st.cv_out = !st.cv_out;
            end else begin
                next_st.cv_cnt = st.cv_cnt + 7'h01;
            end
        end else if (st.cv_act_sel > CSA_SRC_PRESYS) begin
            next_st.cv_out = 1'b0;
        end

        // Output pin clock: toggle every div+1 half periods
        op_edge = sel_edge(st.op_act_sel, src_edge);
        if (!st.op_out && {st.op_sel, st.op_div} != {st.op_act_sel, st.op_act_div}) begin
            next_st.op_act_sel = st.op_sel;
            next_st.op_act_div = st.op_div;
            next_st.op_cnt = 8'h00;
        end else if (op_edge) begin
            if (st.op_cnt >= st.op_act_div) begin
                next_st.op_cnt = 8'h00;
                next_st.op_out = !st.op_out;
            end else begin
                next_st.op_cnt = st.op_cnt + 8'h01;
            end
        end else if (st.op_act_sel > CSA_SRC_PRESYS) begin
            next_st.op_out = 1'b0;
        end

        // APB answer: ready and data prepared in the setup cycle
        next_st.pready = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (setup) begin
            case (paddr)
                CSA_ADDR_CONFIG: begin
                    next_st.prdata[CSA_CFG_REQ_LSB +: 3] = st.sys_req;
                    next_st.prdata[CSA_CFG_MON_LSB +: 2] = st.mon_per;
                    next_st.prdata[CSA_CFG_LOSS_IE_BIT] = st.loss_ie;
                end
                CSA_ADDR_STATUS: begin
                    next_st.prdata[CSA_STS_SRC_LSB +: 3] = st.active_src;
                    next_st.prdata[CSA_STS_LOSS_BIT] = st.loss;
                end
                CSA_ADDR_CONV: begin
                    // Bit 3 stays zero
                    next_st.prdata[CSA_CONV_SEL_LSB +: 3] = st.cv_sel;
                    next_st.prdata[CSA_CONV_DIV_LSB +: 3] = st.cv_div;
                end
                CSA_ADDR_PIN: begin
                    next_st.prdata[CSA_PIN_SEL_LSB +: 3] = st.op_sel;
                    next_st.prdata[CSA_PIN_DIV_LSB +: 8] = st.op_div;
                end
                CSA_ADDR_FORCE: next_st.prdata = st.force_en;
                default: next_st.pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.sys_req <= CSA_RST_REQ;
            st.mon_per <= CSA_RST_MON;
            st.loss_ie <= CSA_RST_LOSS_IE;
            st.active_src <= CSA_SRC_FAST_RC;
            st.cv_sel <= CSA_RST_SEL;
            st.cv_div <= CSA_RST_CONV_DIV;
            st.cv_act_sel <= CSA_RST_SEL;
            st.cv_act_div <= CSA_RST_CONV_DIV;
            st.op_sel <= CSA_RST_SEL;
            st.op_div <= CSA_RST_PIN_DIV;
            st.op_act_sel <= CSA_RST_SEL;
            st.op_act_div <= CSA_RST_PIN_DIV;
            st.force_en <= CSA_RST_FORCE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign periph_clk_en = st.clk_en;
    assign converter_clock = st.cv_out;
    assign output_pin_clock = st.op_out;
    assign clk_loss_irq = st.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_status_ro: assert property (
        (access && pwrite && paddr == CSA_ADDR_STATUS && src_rise == '0)
        |=> $stable(st.active_src) && $stable(st.loss))
        else $error("status changed by a write");
    a_loss_fallback: assert property (
        $rose(st.loss) |-> st.active_src == CSA_SRC_SLOW_RC)
        else $error("loss flag without slow RC fallback");
    a_status_code: assert property (
        st.active_src <= CSA_SRC_PIN)
        else $error("reserved active source code");
    a_switch_done: assert property (
        ($changed(st.active_src) && st.active_src != CSA_SRC_SLOW_RC)
        |-> st.active_src == $past(st.sys_req) && $past(src_rise[st.sys_req]))
        else $error("active source changed without completed switch");
    a_conv_off: assert property (
        (st.cv_act_sel > CSA_SRC_PRESYS)[*2] |-> !converter_clock)
        else $error("converter clock runs while disabled");
    a_conv_bit3: assert property (
        (setup && paddr == CSA_ADDR_CONV) |=> !prdata[3] && pready)
        else $error("converter reserved bit not zero");
    a_pin_toggle: assert property (
        ($changed(st.op_out) && $stable(st.op_act_sel))
        |-> $past(st.op_cnt) == $past(st.op_act_div))
        else $error("pin clock toggled at wrong count");
    a_force_enable: assert property (
        st.force_en[CSA_DMA_FORCE_BIT] |=> periph_clk_en[CSA_DMA_FORCE_BIT])
        else $error("forced bus clock not enabled");
    a_dma_force: assert property (
        dma_write |=> st.force_en[CSA_DMA_FORCE_BIT])
        else $error("DMA write did not set force bit");
    a_loss_irq: assert property (
        (st.loss && st.loss_ie) |=> clk_loss_irq)
        else $error("loss interrupt not raised");
    a_glitch_free: assert property (
        $changed(st.op_act_sel) |-> !$past(st.op_out) && !output_pin_clock)
        else $error("pin select changed while clock high");
endmodule // csa_clock_ctrl

// ---- tb/clock_status_and_aux_clock_select_bench.sv ----
/*
 * Self-checking bench of the clock status and auxiliary clock select block:
 * register table, bus clock enables, generated clocks, switch and loss.
 * Assumes csa_pkg and csa_clock_ctrl are compiled first; one 250 MHz clock.
 */
`timescale 1ns/10ps
module clock_status_and_aux_clock_select_bench;
    import csa_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Row of the register table: address, write, data, read back, error
    typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} csa_reg_row_s;
    // Row of the clock table: select, converter divide, pin divide
    typedef struct {logic [2:0] s; logic [2:0] c; logic [7:0] p;} csa_clk_row_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_write = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, periph_active = 32'h0;
    logic [31:0] prdata, periph_clk_en;
    logic pready, pslverr, converter_clock, output_pin_clock, clk_loss_irq;
    // Crystal gate, cleared to fake a dead system clock
    logic xtal_on = 1'b1;
    // Divider making every oscillator from ref_clk
    logic [6:0] osc_cnt = 7'h00;
    int fail_count = 0;
    int check_count = 0;
    // Source periods in ref_clk cycles, by select code
    int per[8] = '{16, 64, 32, 128, 32, 16, 1, 1};
    csa_reg_row_s regs[11] = '{
        '{CSA_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 1'b0},
        '{CSA_ADDR_CONV, 1'b0, 32'h0, 32'h70, 1'b0},
        '{CSA_ADDR_PIN, 1'b0, 32'h0, 32'h700, 1'b0},
        '{CSA_ADDR_FORCE, 1'b0, 32'h0, 32'h0, 1'b0},
        '{CSA_ADDR_STATUS, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{CSA_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 1'b0},
        '{CSA_ADDR_CONV, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{CSA_ADDR_CONV, 1'b0, 32'h0, 32'h77, 1'b0},
        '{CSA_ADDR_PIN, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{CSA_ADDR_PIN, 1'b0, 32'h0, 32'h7FF, 1'b0},
        '{32'h4030_0014, 1'b0, 32'h0, 32'h0, 1'b1}};
    csa_clk_row_s clks[8] = '{'{3'h0, 3'h1, 8'h02}, '{3'h1, 3'h0, 8'h01},
        '{3'h2, 3'h2, 8'h00}, '{3'h3, 3'h0, 8'h02}, '{3'h4, 3'h1, 8'h01},
        '{3'h5, 3'h3, 8'h02}, '{3'h6, 3'h1, 8'h01}, '{3'h7, 3'h0, 8'h00}};
    ////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Oscillator divider, stepped on the sampling edge by non-blocking update
    always @(posedge ref_clk) begin
        osc_cnt <= osc_cnt + 7'h01;
    end
    csa_clock_ctrl #(.NPERIPH(32)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fast_rc_osc(osc_cnt[3]),
        .slow_rc_osc(osc_cnt[5]), .fast_crystal_osc(osc_cnt[4] & xtal_on),
        .slow_crystal_osc(osc_cnt[6]), .pin_clock_source(osc_cnt[4]),
        .predivided_system_clock(osc_cnt[3]), .dma_write(dma_write),
        .periph_active(periph_active), .periph_clk_en(periph_clk_en),
        .converter_clock(converter_clock), .output_pin_clock(output_pin_clock),
        .clk_loss_irq(clk_loss_irq));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // Edge counts may be one off at the window ends; silent clocks must be exact
    function automatic int near(input int e, input int g);
        return (e > 0 && g >= e - 1 && g <= e + 1) ? e : g;
    endfunction
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 32'h1, 32'h0);
        end
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    // Verdict, shared by the main sequence and the watchdog
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs about 30000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] q;
        logic e;
        logic cp, pp;
        int ce, pe, ec, ep, n;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        // Register table: reset values, read-only places, unmapped word
        foreach (regs[i]) begin
            apb(regs[i].w, regs[i].a, regs[i].d, q, e);
            chk("pslverr", {31'h0, regs[i].e}, {31'h0, e});
            if (!regs[i].w) begin
                chk("register", regs[i].q, q);
            end
        end
        // Bus clock enables, automatic then forced
        periph_active <= 32'h0000_F00F;
        repeat (3) @(posedge ref_clk);
        chk("periph_clk_en", 32'h0000_F00F, periph_clk_en);
        wr(CSA_ADDR_FORCE, 32'h8000_0000);
        repeat (3) @(posedge ref_clk);
        chk("forced", 32'h8000_F00F, periph_clk_en);
        wr(CSA_ADDR_FORCE, 32'h0);
        // A DMA write sets its force bit; software clears it afterwards
        @(posedge ref_clk);
        dma_write <= 1'b1;
        @(posedge ref_clk);
        dma_write <= 1'b0;
        rd(CSA_ADDR_FORCE, q);
        chk("dma force", 32'h1 << CSA_DMA_FORCE_BIT, q);
        chk("dma en", (32'h1 << CSA_DMA_FORCE_BIT) | 32'hF00F, periph_clk_en);
        wr(CSA_ADDR_FORCE, 32'h0);
        rd(CSA_ADDR_FORCE, q);
        chk("force cleared", 32'h0, q);
        // Every select code on both generated clocks, edges counted in a window
        foreach (clks[i]) begin
            wr(CSA_ADDR_CONV, {25'h0, clks[i].s, 1'b0, clks[i].c});
            wr(CSA_ADDR_PIN, {21'h0, clks[i].s, clks[i].p});
            repeat (400) @(posedge ref_clk);
            ce = 0;
            pe = 0;
            cp = converter_clock;
            pp = output_pin_clock;
            repeat (1536) begin
                @(posedge ref_clk);
                ce += int'(converter_clock && !cp);
                pe += int'(output_pin_clock && !pp);
                cp = converter_clock;
                pp = output_pin_clock;
            end
            ec = clks[i].s < 3'h6 ? 1536 / (per[clks[i].s] << clks[i].c) : 0;
            ep = clks[i].s < 3'h6 ? 1536 / (per[clks[i].s] * (int'(clks[i].p) + 1)) : 0;
            chk("converter edges", 32'(ec), 32'(near(ec, ce)));
            chk("pin edges", 32'(ep), 32'(near(ep, pe)));
        end
        // Switch to the fast crystal: status lags the request
        wr(CSA_ADDR_CONFIG, 32'h0010_0002);
        rd(CSA_ADDR_STATUS, q);
        chk("status early", 32'h0, q);
        n = 0;
        do begin
            rd(CSA_ADDR_STATUS, q);
            n++;
        end while (q !== 32'h2 && n < 100);
        chk("status switched", 32'h2, q);
        // Monitor at 4 slow periods: quiet while running, fires once stopped
        wr(CSA_ADDR_CONFIG, 32'h0010_0042);
        repeat (300) @(posedge ref_clk);
        chk("no false loss", 32'h0, {31'h0, clk_loss_irq});
        xtal_on <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (clk_loss_irq !== 1'b1 && n < 1000);
        // Window of 256 cycles: at most one partly used window before the silent one
        chk("loss window", 32'h1, {31'h0, n >= 220 && n <= 520});
        rd(CSA_ADDR_STATUS, q);
        chk("loss status", 32'h9, q);
        // Interrupt enable off and flag cleared by the config write
        wr(CSA_ADDR_CONFIG, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        chk("irq off", 32'h0, {31'h0, clk_loss_irq});
        rd(CSA_ADDR_STATUS, q);
        chk("status slow rc", 32'h1, q);
        // Longer monitor windows, 16 and 64 slow periods, each after a fresh switch
        for (int m = 2; m < 4; m++) begin
            xtal_on <= 1'b1;
            wr(CSA_ADDR_CONFIG, 32'h0010_0002 | (m << CSA_CFG_MON_LSB));
            repeat (200) @(posedge ref_clk);
            xtal_on <= 1'b0;
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (clk_loss_irq !== 1'b1 && n < 9000);
            ec = per[1] * (4 << (2 * m - 2));
            chk("long window", 32'h1, {31'h0, n >= ec - 32 && n <= 2 * ec + 8});
        end
        // Reset in mid-run restores the converter defaults
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(CSA_ADDR_CONV, q);
        chk("conv after reset", 32'h70, q);
        end_of_test();
    end
endmodule // clock_status_and_aux_clock_select_bench
